// ---- include/power_mode_cfg.svh ----
// Register map, field positions, reset values and mode codes of the power mode controller.
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

`define PMC_ADDR_W 4
`define PMC_CTRL_ADDR 4'h0
`define PMC_CTRL_RESET 8'h00
`define PMC_READ_ZERO 32'h0000_0000

`define PMC_BIT_SLOW_REQ 0
`define PMC_BIT_FAST_OFF 1
`define PMC_BIT_IDLE 2
`define PMC_BIT_HALT 3
`define PMC_BIT_RSVD 4
`define PMC_BIT_DEFER 5
`define PMC_BIT_FAST_GOOD 6
`define PMC_BIT_SLOW_GOOD 7

`define PMC_MODE_ACTIVE 2'h0
`define PMC_MODE_SAVE 2'h1
`define PMC_MODE_IDLE 2'h2
`define PMC_MODE_HALT 2'h3

`endif

// ---- include/power_mode_pkg.sv ----
// Types shared by the power mode controller.
package power_mode_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SAVE,
        ST_IDLE,
        ST_HALT,
        ST_WAKE
    } pm_state_e;
endpackage

// ---- rtl/clock_good_sync.sv ----
// Two-flop synchronisers for the oscillator good indicators.
`timescale 1ns/100ps
module clock_good_sync (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [1:0] asyncIn,
    output logic [1:0] syncOut
);
    logic [1:0] meta_q;

    // The first stage feeds only the second stage.
    for (genvar i = 0; i < 2; i++) begin : g_bit
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_q[i] <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                meta_q[i] <= asyncIn[i];
                syncOut[i] <= meta_q[i];
            end
        end
    end
endmodule

// ---- rtl/power_mode_controller.sv ----
// Power mode controller: control/status register, mode sequencer and clock controls.
//
// Summary of operation
// - Byte register: status, defer, reserved, halt, idle, oscoff, slow.
// - Reset clears all control bits, Active mode.
// - Two top bits are read-only hardware status.
// - Slow request zero means Active; one enters Power Save.
// - Software sets slow request; wake-up clears it.
// - Oscillator off bit acts only in Save/Idle.
// - Idle request enters Idle on WAIT, deferred.
// - Halt request enters Halt on WAIT, deferred.
// - Wake-up clears idle and halt, returns Active.
// - Immediate slow switch; bit reads one afterwards.
// - Deferred slow switch; bit reads one at once.
// - Fast good reflects fast clock; gates Active entry.
// - Save or Idle entry from Active needs slow good.
// - Slow good selects main or low-speed indicator.
// - Idle or Halt only from Active or Save.
// - Oscillator stops only after mode entered.
// - In Save, oscillator off stops fast clock.
// - Clearing slow request returns Active; reads one meanwhile.
// - Wake-up: clear oscoff, await fast good, Active.
// - Wake-up stays latched until acknowledge or reset.
// - Mode switch waits for needed clock good.
// - Halt stops all clocks and the oscillator.
// - Idle keeps only controller and timer on slow clock.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "power_mode_cfg.svh"
module power_mode_controller (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [`PMC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic waitExec,
    input wire logic wakeEvent,
    input wire logic intAck,
    input wire logic goodMainClk,
    input wire logic goodLowSpeedClk,
    input wire logic slowSrcSel,
    output logic [1:0] powerMode,
    output logic stopMainOsc,
    output logic cpuOnSlowClk,
    output logic coreClkStop,
    output logic slowClkStop,
    output logic wakeLatched
);
    import power_mode_pkg::*;

    pm_state_e state_q;
    pm_state_e state_d;
    logic waitReq_q;
    logic [31:0] readData_q;
    logic slowReq_q;
    logic slowPend_q;
    logic exitPend_q;
    logic waitPend_q;
    logic deferToWait_q;
    logic fastOscOff_q;
    logic idleReq_q;
    logic haltReq_q;
    logic fastClockGood_q;
    logic slowClockGood_q;
    logic srcSel_q;
    logic srcCaptured_q;
    logic wake_q;
    logic [1:0] powerMode_q;
    logic stopMainOsc_q;
    logic cpuOnSlowClk_q;
    logic coreClkStop_q;
    logic slowClkStop_q;
    logic [1:0] goodSync;
    logic regHit;
    logic wrAcc;
    logic [7:0] ctrlView;
    logic waitSeen;
    logic waitActive;

    clock_good_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .asyncIn({goodLowSpeedClk, goodMainClk}),
        .syncOut(goodSync)
    );

    // Bus slave: one wait cycle, then the access completes at the edge where
    // waitrequest is seen low. Unmapped addresses read zero and ignore writes.
    assign regHit = (address == `PMC_CTRL_ADDR);
    assign wrAcc = write && !waitReq_q && regHit && byteenable[0];
    assign ctrlView = {slowClockGood_q, fastClockGood_q, deferToWait_q, 1'b0,
                       haltReq_q, idleReq_q, fastOscOff_q, slowReq_q};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            waitReq_q <= 1'b1;
            readData_q <= `PMC_READ_ZERO;
        end else if ((read || write) && waitReq_q) begin
            waitReq_q <= 1'b0;
            readData_q <= (read && regHit) ? {24'h00_0000, ctrlView} : `PMC_READ_ZERO;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    // Slow clock source is caught once after reset release, like a strap.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            srcCaptured_q <= 1'b0;
            srcSel_q <= 1'b0;
        end else if (!srcCaptured_q) begin
            srcCaptured_q <= 1'b1;
            srcSel_q <= slowSrcSel;
        end
    end

    // Status bits follow hardware only; writes cannot reach them.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fastClockGood_q <= 1'b0;
            slowClockGood_q <= 1'b0;
        end else begin
            fastClockGood_q <= goodSync[0];
            slowClockGood_q <= srcSel_q ? goodSync[1] : goodSync[0];
        end
    end

    // Wake-up latch; a new event wins over an acknowledge in the same cycle.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_q <= 1'b0;
        end else if (wakeEvent) begin
            wake_q <= 1'b1;
        end else if (intAck) begin
            wake_q <= 1'b0;
        end
    end

    // Plain control bits. Wake-up clearing wins over a simultaneous write.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            deferToWait_q <= 1'b0;
            fastOscOff_q <= 1'b0;
            idleReq_q <= 1'b0;
            haltReq_q <= 1'b0;
        end else begin
            if (wrAcc) begin
                deferToWait_q <= writedata[`PMC_BIT_DEFER];
                fastOscOff_q <= writedata[`PMC_BIT_FAST_OFF];
                idleReq_q <= writedata[`PMC_BIT_IDLE];
                haltReq_q <= writedata[`PMC_BIT_HALT];
            end
            if (wakeEvent) begin
                fastOscOff_q <= 1'b0;
                idleReq_q <= 1'b0;
                haltReq_q <= 1'b0;
            end
        end
    end

    // A WAIT counts from Active only when deferral was already set.
    assign waitActive = waitExec || waitPend_q;
    assign waitSeen = (state_q == ST_SAVE) ? waitActive : (deferToWait_q && waitActive);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_ACTIVE: begin
                if (wakeEvent) begin
                    state_d = ST_ACTIVE;
                end else if (waitSeen && haltReq_q) begin
                    state_d = ST_HALT;
                end else if (waitSeen && idleReq_q && slowClockGood_q) begin
                    state_d = ST_IDLE;
                end else if (waitSeen && slowReq_q && slowClockGood_q) begin
                    state_d = ST_SAVE;
                end else if (slowPend_q && slowClockGood_q) begin
                    state_d = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (wakeEvent) begin
                    state_d = ST_WAKE;
                end else if (waitSeen && haltReq_q) begin
                    state_d = ST_HALT;
                end else if (waitSeen && idleReq_q) begin
                    state_d = ST_IDLE;
                end else if (exitPend_q && fastClockGood_q) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_IDLE, ST_HALT: begin
                if (wakeEvent) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (fastClockGood_q) begin
                    state_d = ST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // A counted WAIT whose mode entry still waits for a clock is held until the clock is good.
    // Any other WAIT is dropped, so that a later register write cannot act on a stale WAIT.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            waitPend_q <= 1'b0;
        end else if (wakeEvent || wrAcc || state_d != state_q) begin
            waitPend_q <= 1'b0;
        end else if (waitExec && (state_q == ST_SAVE || deferToWait_q)
                     && (idleReq_q || (state_q == ST_ACTIVE && slowReq_q))) begin
            waitPend_q <= 1'b1;
        end
    end

    // Slow-mode request bit and its pending switches.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            slowReq_q <= 1'b0;
            slowPend_q <= 1'b0;
            exitPend_q <= 1'b0;
        end else if (wakeEvent) begin
            slowReq_q <= 1'b0;
            slowPend_q <= 1'b0;
            exitPend_q <= 1'b0;
        end else if (state_q == ST_ACTIVE && state_d == ST_SAVE) begin
            slowReq_q <= 1'b1;
            slowPend_q <= 1'b0;
        end else if (state_q == ST_SAVE && state_d == ST_ACTIVE) begin
            slowReq_q <= 1'b0;
            exitPend_q <= 1'b0;
        end else if (wrAcc && state_q == ST_ACTIVE) begin
            if (!writedata[`PMC_BIT_SLOW_REQ]) begin
                slowReq_q <= 1'b0;
                slowPend_q <= 1'b0;
            end else if (writedata[`PMC_BIT_DEFER]) begin
                slowReq_q <= 1'b1;
                slowPend_q <= 1'b0;
            end else begin
                slowPend_q <= 1'b1;
            end
        end else if (wrAcc && state_q == ST_SAVE) begin
            exitPend_q <= !writedata[`PMC_BIT_SLOW_REQ];
        end
    end

    // Clock controls derived from the mode actually in force.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            powerMode_q <= `PMC_MODE_ACTIVE;
            stopMainOsc_q <= 1'b0;
            cpuOnSlowClk_q <= 1'b0;
            coreClkStop_q <= 1'b0;
            slowClkStop_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_ACTIVE: begin
                    powerMode_q <= `PMC_MODE_ACTIVE;
                    stopMainOsc_q <= 1'b0;
                    cpuOnSlowClk_q <= 1'b0;
                    coreClkStop_q <= 1'b0;
                    slowClkStop_q <= 1'b0;
                end
                ST_SAVE: begin
                    powerMode_q <= `PMC_MODE_SAVE;
                    stopMainOsc_q <= fastOscOff_q;
                    cpuOnSlowClk_q <= 1'b1;
                    coreClkStop_q <= 1'b0;
                    slowClkStop_q <= 1'b0;
                end
                ST_IDLE: begin
                    powerMode_q <= `PMC_MODE_IDLE;
                    stopMainOsc_q <= fastOscOff_q;
                    cpuOnSlowClk_q <= 1'b1;
                    coreClkStop_q <= 1'b1;
                    slowClkStop_q <= 1'b0;
                end
                ST_HALT: begin
                    powerMode_q <= `PMC_MODE_HALT;
                    stopMainOsc_q <= 1'b1;
                    cpuOnSlowClk_q <= 1'b1;
                    coreClkStop_q <= 1'b1;
                    slowClkStop_q <= 1'b1;
                end
                ST_WAKE: begin
                    stopMainOsc_q <= 1'b0;
                    slowClkStop_q <= 1'b0;
                end
            endcase
        end
    end

    assign readdata = readData_q;
    assign waitrequest = waitReq_q;
    assign powerMode = powerMode_q;
    assign stopMainOsc = stopMainOsc_q;
    assign cpuOnSlowClk = cpuOnSlowClk_q;
    assign coreClkStop = coreClkStop_q;
    assign slowClkStop = slowClkStop_q;
    assign wakeLatched = wake_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_reserved_zero;
        !waitReq_q |-> !readData_q[`PMC_BIT_RSVD];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

    property p_fast_good_follow;
        ##1 fastClockGood_q == $past(goodSync[0]);
    endproperty
    a_fast_good_follow: assert property (p_fast_good_follow) else $error("fast good not hardware");

    property p_active_needs_fast;
        (state_q != ST_ACTIVE && state_d == ST_ACTIVE) |-> fastClockGood_q;
    endproperty
    a_active_needs_fast: assert property (p_active_needs_fast) else $error("active without fast");

    property p_save_needs_slow;
        (state_q == ST_ACTIVE && (state_d == ST_SAVE || state_d == ST_IDLE)) |-> slowClockGood_q;
    endproperty
    a_save_needs_slow: assert property (p_save_needs_slow) else $error("low mode without slow");

    property p_low_entry_source;
        ((state_d == ST_IDLE || state_d == ST_HALT) && state_d != state_q)
            |-> (state_q == ST_ACTIVE || state_q == ST_SAVE);
    endproperty
    a_low_entry_source: assert property (p_low_entry_source) else $error("bad idle/halt source");

    property p_wake_clears;
        wakeEvent |=> !slowReq_q && !idleReq_q && !haltReq_q && !fastOscOff_q && wake_q;
    endproperty
    a_wake_clears: assert property (p_wake_clears) else $error("wake did not clear bits");

    property p_immediate_late;
        (wrAcc && state_q == ST_ACTIVE && !slowReq_q && writedata[`PMC_BIT_SLOW_REQ]
            && !writedata[`PMC_BIT_DEFER] && !slowClockGood_q && !wakeEvent) |=> !slowReq_q;
    endproperty
    a_immediate_late: assert property (p_immediate_late) else $error("slow bit set early");

    property p_deferred_now;
        (wrAcc && state_q == ST_ACTIVE && writedata[`PMC_BIT_SLOW_REQ]
            && writedata[`PMC_BIT_DEFER] && !wakeEvent) |=> slowReq_q;
    endproperty
    a_deferred_now: assert property (p_deferred_now) else $error("deferred slow bit late");

    property p_halt_osc;
        state_q == ST_HALT |=> stopMainOsc_q && coreClkStop_q && slowClkStop_q;
    endproperty
    a_halt_osc: assert property (p_halt_osc) else $error("halt left clocks on");

    property p_active_osc;
        state_q == ST_ACTIVE |=> !stopMainOsc_q;
    endproperty
    a_active_osc: assert property (p_active_osc) else $error("oscillator off in active");

    property p_bus_answer;
        (read || write) && waitReq_q |=> !waitReq_q ##1 waitReq_q;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");

    c_enter_save: cover property (state_q == ST_ACTIVE ##1 state_q == ST_SAVE);
    c_enter_halt: cover property (state_q == ST_ACTIVE ##1 state_q == ST_HALT);
    c_wake_idle: cover property (state_q == ST_IDLE ##1 state_q == ST_WAKE ##[1:20] state_q == ST_ACTIVE);
    c_save_exit: cover property (state_q == ST_SAVE ##1 state_q == ST_ACTIVE);
endmodule

// ---- bench/osc_model.sv ----
// Behavioural model of the fast oscillator and its start-up timer.
`timescale 1ns/100ps
module osc_model #(
    parameter int START_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic stopMainOsc,
    output logic goodMainClk
);
    int count_q;

    // The good flag drops at once on a stop and returns only after a full start-up run.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 0;
            goodMainClk <= 1'b0;
        end else if (stopMainOsc) begin
            count_q <= 0;
            goodMainClk <= 1'b0;
        end else if (count_q < START_CYCLES) begin
            count_q <= count_q + 1;
        end else begin
            goodMainClk <= 1'b1;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking testbench of the power mode controller.
`timescale 1ns/100ps
`include "power_mode_cfg.svh"
module tb_top;
    logic ref_clk;
    logic arst_n;
    logic [`PMC_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic waitExec;
    logic wakeEvent;
    logic intAck;
    logic goodMainClk;
    logic goodLowSpeedClk;
    logic slowSrcSel;
    logic [1:0] powerMode;
    logic stopMainOsc;
    logic cpuOnSlowClk;
    logic coreClkStop;
    logic slowClkStop;
    logic wakeLatched;
    int miscompares;
    int cmp_count;
    int seed;
    logic [7:0] rnd;
    logic [31:0] dummy;

    power_mode_controller i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .waitExec(waitExec),
        .wakeEvent(wakeEvent), .intAck(intAck), .goodMainClk(goodMainClk),
        .goodLowSpeedClk(goodLowSpeedClk), .slowSrcSel(slowSrcSel),
        .powerMode(powerMode), .stopMainOsc(stopMainOsc), .cpuOnSlowClk(cpuOnSlowClk),
        .coreClkStop(coreClkStop), .slowClkStop(slowClkStop), .wakeLatched(wakeLatched)
    );

    osc_model i_osc (
        .ref_clk(ref_clk), .arst_n(arst_n), .stopMainOsc(stopMainOsc),
        .goodMainClk(goodMainClk)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_port(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected port value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low, as the bus demands.
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= addr;
        read <= !wr;
        write <= wr;
        writedata <= {24'h000000, data};
        byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
    endtask

    task automatic wr8(input logic [7:0] d);
        bus(1'b1, `PMC_CTRL_ADDR, d, 4'h1, dummy);
    endtask

    task automatic rdchk(input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, `PMC_CTRL_ADDR, 8'h00, 4'hF, rd);
        check_reg(rd, {24'h000000, exp});
    endtask

    task automatic pulse(input int which);
        @(posedge ref_clk);
        if (which == 0) waitExec <= 1'b1;
        if (which == 1) wakeEvent <= 1'b1;
        if (which == 2) intAck <= 1'b1;
        @(posedge ref_clk);
        waitExec <= 1'b0;
        wakeEvent <= 1'b0;
        intAck <= 1'b0;
    endtask

    task automatic wait_mode(input logic [1:0] exp);
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            #1;
            if (powerMode === exp) break;
        end
        check_port(powerMode, exp);
        if (powerMode !== exp) begin
            conclude();
        end
    endtask

    initial begin
        arst_n = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'h0;
        waitExec = 1'b0;
        wakeEvent = 1'b0;
        intAck = 1'b0;
        goodLowSpeedClk = 1'b1;
        slowSrcSel = 1'b1;
        miscompares = 0;
        cmp_count = 0;
        seed = 32'h68530836;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (30) @(posedge ref_clk);
        rdchk(8'hC0);
        wr8(8'hD0);
        rdchk(8'hC0);
        bus(1'b1, `PMC_CTRL_ADDR, 8'h20, 4'h0, dummy);
        rdchk(8'hC0);
        bus(1'b0, 4'h4, 8'h00, 4'hF, dummy);
        check_reg(dummy, `PMC_READ_ZERO);
        // Random bytes with no mode request set, so the device must stay Active.
        repeat (8) begin
            rnd = 8'($random(seed));
            rnd = rnd & 8'hF2;
            wr8(rnd);
            rdchk((rnd & 8'h22) | 8'hC0);
            check_port({1'b0, stopMainOsc}, 2'h0);
        end
        // Save is held off while the slow clock is not yet good.
        goodLowSpeedClk <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wr8(8'h01);
        repeat (5) @(posedge ref_clk);
        check_port(powerMode, `PMC_MODE_ACTIVE);
        rdchk(8'h40);
        goodLowSpeedClk <= 1'b1;
        wait_mode(`PMC_MODE_SAVE);
        rdchk(8'hC1);
        check_port({1'b0, cpuOnSlowClk}, 2'h1);
        wr8(8'h03);
        repeat (3) @(posedge ref_clk);
        check_port({1'b0, stopMainOsc}, 2'h1);
        repeat (5) @(posedge ref_clk);
        rdchk(8'h83);
        wr8(8'h01);
        repeat (40) @(posedge ref_clk);
        rdchk(8'hC1);
        wr8(8'h00);
        wait_mode(`PMC_MODE_ACTIVE);
        rdchk(8'hC0);
        wr8(8'h21);
        rdchk(8'hE1);
        check_port(powerMode, `PMC_MODE_ACTIVE);
        pulse(0);
        wait_mode(`PMC_MODE_SAVE);
        pulse(1);
        wait_mode(`PMC_MODE_ACTIVE);
        rdchk(8'hE0);
        check_port({1'b0, wakeLatched}, 2'h1);
        pulse(2);
        #1;
        check_port({1'b0, wakeLatched}, 2'h0);
        wr8(8'h04);
        pulse(0);
        repeat (5) @(posedge ref_clk);
        check_port(powerMode, `PMC_MODE_ACTIVE);
        wr8(8'h26);
        repeat (3) @(posedge ref_clk);
        check_port(powerMode, `PMC_MODE_ACTIVE);
        pulse(0);
        wait_mode(`PMC_MODE_IDLE);
        check_port({1'b0, coreClkStop}, 2'h1);
        repeat (3) @(posedge ref_clk);
        check_port({1'b0, stopMainOsc}, 2'h1);
        pulse(1);
        wait_mode(`PMC_MODE_ACTIVE);
        rdchk(8'hE0);
        check_port({coreClkStop, stopMainOsc}, 2'h0);
        pulse(2);
        wr8(8'h28);
        pulse(0);
        wait_mode(`PMC_MODE_HALT);
        #1;
        check_port({slowClkStop, stopMainOsc}, 2'h3);
        repeat (30) @(posedge ref_clk);
        pulse(1);
        // Active must not return until the restarted oscillator reports good.
        for (int n = 0; n < 20 && goodMainClk !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
            check_port(powerMode, `PMC_MODE_HALT);
        end
        wait_mode(`PMC_MODE_ACTIVE);
        rdchk(8'hE0);
        pulse(2);
        // Second reset with the divided main clock as slow source.
        arst_n <= 1'b0;
        slowSrcSel <= 1'b0;
        goodLowSpeedClk <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (30) @(posedge ref_clk);
        rdchk(8'hC0);
        check_port(powerMode, `PMC_MODE_ACTIVE);
        conclude();
    end
endmodule
